/* File: core/wpm_wake_match.sv */
// masked crc wake pattern matcher for wake slots 1 and 2
//
// Behaviour
// - Each slot runs 802.3 CRC over mask-selected bytes and compares with expected.
// - Slot 1 expected CRC low half, read/write at 0x40, resets to zero.
// - Slot 1 expected CRC high half at 0x42, resets zero, forms 32-bit value.
// - Slot 2 expected CRC low half, read/write at 0x50, resets to zero.
// - Slot 2 expected CRC high half, read/write at 0x52, resets to zero.
// - Slot 1 mask at 0x44: bit n selects frame byte n+1.
// - Slot 1 mask at 0x46 selects bytes 17 to 32, bit 0 is byte 17.
// - Slot 1 mask at 0x48 selects bytes 33 to 48, bit 0 is byte 33.
// - Slot 1 mask at 0x4A selects bytes 49 to 64; later bytes never count.
// - Slot 2 mask at 0x54: bit n selects frame byte n+1.
// - Slot 2 mask at 0x56 selects bytes 17 to 32, bit 0 is byte 17.
// - Slot 2 mask at 0x58 selects bytes 33 to 48, resets to zero.
// - Slot 2 mask at 0x5A selects bytes 49 to 64, bit 15 is byte 64.
// - Addresses 0x3C-0x3F and 0x4C-0x4F hold no storage, read as zero.
// - Slot 1 matches only while its detect enable is set.
// - Slot 2 matches only while its detect enable is set.
`timescale 1ns/1ns
`include "wpm_consts.svh"

module wpm_wake_match (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [1:0]  i_reg_be,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    // slot enables from the wake control register
    input  wire logic        i_slot1_detect_enable,
    input  wire logic        i_slot2_detect_enable,
    // received frame bytes from the mac
    input  wire logic        i_rx_valid,
    input  wire logic        i_rx_sof,
    input  wire logic        i_rx_eof,
    input  wire logic [7:0]  i_rx_data,
    // wake detection events
    output logic             o_slot1_wake,
    output logic             o_slot2_wake
);

    // one crc step over a byte, lsb first
    function automatic wpm_pkg::wpm_crc_t crc_byte(input wpm_pkg::wpm_crc_t c_in, input logic [7:0] d);
        wpm_pkg::wpm_crc_t c;
        logic              fb;
        c = c_in;
        for (int i = 0; i < 8; i++)
        begin
            fb = c[0] ^ d[i];
            c  = {1'b0, c[31:1]};
            if (fb)
            begin
                c = c ^ `WPM_CRC_POLY;
            end
        end
        return c;
    endfunction

    // byte-enable merge of a 16-bit register write
    function automatic wpm_pkg::wpm_reg16_t merge16(input wpm_pkg::wpm_reg16_t old, input logic [1:0] be,
                                                    input wpm_pkg::wpm_reg16_t wd);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    wpm_pkg::wpm_reg16_t      crc_low   [2];
    wpm_pkg::wpm_reg16_t      crc_high  [2];
    wpm_pkg::wpm_reg16_t      mask_word [2][4];
    wpm_pkg::wpm_crc_t        crc_run   [2];
    wpm_pkg::wpm_crc_t        next_crc  [2];
    logic [63:0]              mask_all  [2];
    logic [31:0]              expect_crc[2];
    logic [1:0]               slot_en;
    logic [1:0]               next_wake;
    logic [6:0]               byte_cnt;
    logic [6:0]               cur_idx;
    logic                     accept;
    logic                     in_window;
    logic                     in_reserved;
    wpm_pkg::wpm_frame_state_t state;

    // byte acceptance and index of the current byte
    assign accept    = i_rx_valid && (i_rx_sof || state == wpm_pkg::WPM_FRAME);
    assign cur_idx   = i_rx_sof ? 7'h00 : byte_cnt;
    assign in_window = cur_idx < `WPM_MASK_BYTES;
    assign slot_en   = {i_slot2_detect_enable, i_slot1_detect_enable};

    // reserved address windows, watched by the checks below
    assign in_reserved = (i_reg_addr >= `WPM_RSV_A_FIRST && i_reg_addr <= `WPM_RSV_A_LAST) ||
                         (i_reg_addr >= `WPM_RSV_B_FIRST && i_reg_addr <= `WPM_RSV_B_LAST);

    // frame state tracking
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= wpm_pkg::WPM_IDLE;
        end
        else if (accept)
        begin
            unique case (1'b1)
                i_rx_eof: state <= wpm_pkg::WPM_IDLE;
                default:  state <= wpm_pkg::WPM_FRAME;
            endcase
        end
    end

    // byte counter, saturates once past the masked window
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            byte_cnt <= 7'h00;
        end
        else if (accept)
        begin
            byte_cnt <= in_window ? cur_idx + 7'h01 : `WPM_MASK_BYTES;
        end
    end

    // register writes with byte enables
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            for (int s = 0; s < 2; s++)
            begin
                crc_low[s]  <= `WPM_RST_CRC;
                crc_high[s] <= `WPM_RST_CRC;
                for (int w = 0; w < 4; w++)
                begin
                    mask_word[s][w] <= `WPM_RST_MASK;
                end
            end
        end
        else if (i_reg_wr)
        begin
            unique case (i_reg_addr)
                `WPM_OFS_S1_CRC_LOW:    crc_low[0]      <= merge16(crc_low[0], i_reg_be, i_reg_wdata);
                `WPM_OFS_S1_CRC_HIGH:   crc_high[0]     <= merge16(crc_high[0], i_reg_be, i_reg_wdata);
                `WPM_OFS_S1_MASK_1_16:  mask_word[0][0] <= merge16(mask_word[0][0], i_reg_be, i_reg_wdata);
                `WPM_OFS_S1_MASK_17_32: mask_word[0][1] <= merge16(mask_word[0][1], i_reg_be, i_reg_wdata);
                `WPM_OFS_S1_MASK_33_48: mask_word[0][2] <= merge16(mask_word[0][2], i_reg_be, i_reg_wdata);
                `WPM_OFS_S1_MASK_49_64: mask_word[0][3] <= merge16(mask_word[0][3], i_reg_be, i_reg_wdata);
                `WPM_OFS_S2_CRC_LOW:    crc_low[1]      <= merge16(crc_low[1], i_reg_be, i_reg_wdata);
                `WPM_OFS_S2_CRC_HIGH:   crc_high[1]     <= merge16(crc_high[1], i_reg_be, i_reg_wdata);
                `WPM_OFS_S2_MASK_1_16:  mask_word[1][0] <= merge16(mask_word[1][0], i_reg_be, i_reg_wdata);
                `WPM_OFS_S2_MASK_17_32: mask_word[1][1] <= merge16(mask_word[1][1], i_reg_be, i_reg_wdata);
                `WPM_OFS_S2_MASK_33_48: mask_word[1][2] <= merge16(mask_word[1][2], i_reg_be, i_reg_wdata);
                `WPM_OFS_S2_MASK_49_64: mask_word[1][3] <= merge16(mask_word[1][3], i_reg_be, i_reg_wdata);
                default:                ; // reserved and unmapped writes are dropped
            endcase
        end
    end

    // registered read data, held until the next read
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_reg_rdata <= `WPM_RST_RDATA;
        end
        else if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                `WPM_OFS_S1_CRC_LOW:    o_reg_rdata <= crc_low[0];
                `WPM_OFS_S1_CRC_HIGH:   o_reg_rdata <= crc_high[0];
                `WPM_OFS_S1_MASK_1_16:  o_reg_rdata <= mask_word[0][0];
                `WPM_OFS_S1_MASK_17_32: o_reg_rdata <= mask_word[0][1];
                `WPM_OFS_S1_MASK_33_48: o_reg_rdata <= mask_word[0][2];
                `WPM_OFS_S1_MASK_49_64: o_reg_rdata <= mask_word[0][3];
                `WPM_OFS_S2_CRC_LOW:    o_reg_rdata <= crc_low[1];
                `WPM_OFS_S2_CRC_HIGH:   o_reg_rdata <= crc_high[1];
                `WPM_OFS_S2_MASK_1_16:  o_reg_rdata <= mask_word[1][0];
                `WPM_OFS_S2_MASK_17_32: o_reg_rdata <= mask_word[1][1];
                `WPM_OFS_S2_MASK_33_48: o_reg_rdata <= mask_word[1][2];
                `WPM_OFS_S2_MASK_49_64: o_reg_rdata <= mask_word[1][3];
                default:                o_reg_rdata <= `WPM_RST_RDATA;
            endcase
        end
    end

    // per-slot masked crc and compare
    for (genvar s = 0; s < 2; s++)
    begin : g_slot
        wpm_pkg::wpm_crc_t base;
        logic              sel;

        assign mask_all[s]   = {mask_word[s][3], mask_word[s][2],
                                mask_word[s][1], mask_word[s][0]};
        assign expect_crc[s] = {crc_high[s], crc_low[s]};
        assign base          = i_rx_sof ? `WPM_CRC_INIT : crc_run[s];
        assign sel           = in_window && mask_all[s][cur_idx[5:0]];
        assign next_crc[s]   = sel ? crc_byte(base, i_rx_data) : base;
        assign next_wake[s]  = accept && i_rx_eof && slot_en[s] && (~next_crc[s] == expect_crc[s]);

        // running crc of the current frame
        always_ff @(posedge i_core_clk or negedge i_resetn)
        begin
            if (!i_resetn)
            begin
                crc_run[s] <= `WPM_CRC_INIT;
            end
            else if (accept)
            begin
                crc_run[s] <= next_crc[s];
            end
        end
    end

    // one-cycle wake events
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_slot1_wake <= 1'b0;
            o_slot2_wake <= 1'b0;
        end
        else
        begin
            o_slot1_wake <= next_wake[0];
            o_slot2_wake <= next_wake[1];
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_frame_end;
        accept && i_rx_eof;
    endsequence

    sequence s_write_full(logic [7:0] ofs);
        i_reg_wr && i_reg_addr == ofs && i_reg_be == 2'b11;
    endsequence

    a_slot1_needs_enable: assert property (o_slot1_wake |-> $past(i_slot1_detect_enable))
        else $error("slot 1 woke while disabled");
    a_slot2_needs_enable: assert property (o_slot2_wake |-> $past(i_slot2_detect_enable))
        else $error("slot 2 woke while disabled");
    a_wake_at_end: assert property ((o_slot1_wake || o_slot2_wake) |-> $past(accept && i_rx_eof))
        else $error("wake event without frame end");

    sequence s_read_back(logic [7:0] ofs);
        i_reg_rd && !i_reg_wr && i_reg_addr == ofs;
    endsequence

    // frame-end decision per slot
    a_match_gives_wake: assert property (s_frame_end ##0 (slot_en[0] && ~next_crc[0] == expect_crc[0])
                                         |=> o_slot1_wake)
        else $error("slot 1 match missed");
    a_slot2_match_wake: assert property (s_frame_end ##0 (slot_en[1] && ~next_crc[1] == expect_crc[1])
                                         |=> o_slot2_wake)
        else $error("slot 2 match missed");
    a_slot1_quiet: assert property (s_frame_end ##0 !(slot_en[0] && ~next_crc[0] == expect_crc[0])
                                    |=> !o_slot1_wake)
        else $error("slot 1 woke without a match");
    a_slot2_quiet: assert property (s_frame_end ##0 !(slot_en[1] && ~next_crc[1] == expect_crc[1])
                                    |=> !o_slot2_wake)
        else $error("slot 2 woke without a match");

    // reserved windows hold nothing
    a_reserved_reads_zero: assert property (i_reg_rd && in_reserved |=> o_reg_rdata == `WPM_RST_RDATA)
        else $error("reserved address read nonzero");
    a_reserved_write_kept: assert property (i_reg_wr && in_reserved
                                            |=> expect_crc[0] == $past(expect_crc[0])
                                            && expect_crc[1] == $past(expect_crc[1])
                                            && mask_all[0] == $past(mask_all[0])
                                            && mask_all[1] == $past(mask_all[1]))
        else $error("reserved write changed a register");

    // readback on the edge right after a full write
    a_s1_low_readback: assert property (s_write_full(`WPM_OFS_S1_CRC_LOW) ##1
                                        s_read_back(`WPM_OFS_S1_CRC_LOW)
                                        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("slot 1 crc low readback wrong");
    a_s2_high_readback: assert property (s_write_full(`WPM_OFS_S2_CRC_HIGH) ##1
                                         s_read_back(`WPM_OFS_S2_CRC_HIGH)
                                         |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("slot 2 crc high readback wrong");
    a_s1_mask3_readback: assert property (s_write_full(`WPM_OFS_S1_MASK_49_64) ##1
                                          s_read_back(`WPM_OFS_S1_MASK_49_64)
                                          |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("slot 1 mask 49-64 readback wrong");
    a_s2_mask2_readback: assert property (s_write_full(`WPM_OFS_S2_MASK_33_48) ##1
                                          s_read_back(`WPM_OFS_S2_MASK_33_48)
                                          |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("slot 2 mask 33-48 readback wrong");
    a_s2_mask3_readback: assert property (s_write_full(`WPM_OFS_S2_MASK_49_64) ##1
                                          s_read_back(`WPM_OFS_S2_MASK_49_64)
                                          |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("slot 2 mask 49-64 readback wrong");

    // crc window and mask selection
    a_beyond_window_ignored: assert property (accept && !i_rx_sof && byte_cnt == `WPM_MASK_BYTES
                                              |=> crc_run[0] == $past(crc_run[0])
                                              && crc_run[1] == $past(crc_run[1]))
        else $error("byte past 64 changed crc");
    a_count_saturates: assert property (accept && !i_rx_sof && byte_cnt == `WPM_MASK_BYTES
                                        |=> byte_cnt == `WPM_MASK_BYTES)
        else $error("byte counter left its saturated value");
    a_unmasked_skipped: assert property (accept && !i_rx_sof && in_window && !mask_all[1][cur_idx[5:0]]
                                         |=> crc_run[1] == $past(crc_run[1]))
        else $error("unmasked byte changed slot 2 crc");
    a_first_byte_bit0: assert property (accept && i_rx_sof && mask_all[0][0]
                                        |=> crc_run[0] == crc_byte(`WPM_CRC_INIT, $past(i_rx_data)))
        else $error("first byte not taken by bit 0");
    a_sof_restarts: assert property (accept && i_rx_sof && !mask_all[1][0]
                                     |=> crc_run[1] == `WPM_CRC_INIT)
        else $error("frame start did not restart slot 2 crc");

endmodule

/* File: common/wpm_consts.svh */
// register offsets, reset values and crc constants for the wake pattern matcher
`ifndef WPM_CONSTS_SVH
`define WPM_CONSTS_SVH

// register offsets, byte addresses of 16-bit registers
`define WPM_OFS_S1_CRC_LOW    8'h40
`define WPM_OFS_S1_CRC_HIGH   8'h42
`define WPM_OFS_S1_MASK_1_16  8'h44
`define WPM_OFS_S1_MASK_17_32 8'h46
`define WPM_OFS_S1_MASK_33_48 8'h48
`define WPM_OFS_S1_MASK_49_64 8'h4A
`define WPM_OFS_S2_CRC_LOW    8'h50
`define WPM_OFS_S2_CRC_HIGH   8'h52
`define WPM_OFS_S2_MASK_1_16  8'h54
`define WPM_OFS_S2_MASK_17_32 8'h56
`define WPM_OFS_S2_MASK_33_48 8'h58
`define WPM_OFS_S2_MASK_49_64 8'h5A

// reserved address windows
`define WPM_RSV_A_FIRST       8'h3C
`define WPM_RSV_A_LAST        8'h3F
`define WPM_RSV_B_FIRST       8'h4C
`define WPM_RSV_B_LAST        8'h4F

// reset values
`define WPM_RST_CRC           16'h0000
`define WPM_RST_MASK          16'h0000
`define WPM_RST_RDATA         16'h0000

// crc-32, reflected form
`define WPM_CRC_INIT          32'hFFFFFFFF
`define WPM_CRC_POLY          32'hEDB88320

// number of frame bytes covered by the mask
`define WPM_MASK_BYTES        7'h40

`endif

/* File: common/wpm_pkg.sv */
// types shared by the wake pattern matcher
package wpm_pkg;

    // receive frame tracking, one-hot
    typedef enum logic [1:0] {
        WPM_IDLE  = 2'b01,
        WPM_FRAME = 2'b10
    } wpm_frame_state_t;

    typedef logic [15:0] wpm_reg16_t;
    typedef logic [31:0] wpm_crc_t;

endpackage

/* File: verification/wpm_frame_source.sv */
// frame source model standing in for the mac receive path
`timescale 1ns/1ns

module wpm_frame_source (
    // clock
    input  wire logic       i_core_clk,
    // received byte stream
    output logic            o_rx_valid,
    output logic            o_rx_sof,
    output logic            o_rx_eof,
    output logic [7:0]      o_rx_data
);
    logic [7:0] frame [0:79];

    // idle line, data never left showing a stale byte
    initial
    begin
        o_rx_valid = 1'b0;
        o_rx_sof   = 1'b0;
        o_rx_eof   = 1'b0;
        o_rx_data  = 8'hA5;
    end

    // send len bytes at falling edges, optionally one idle cycle between bytes
    task automatic send(input int len, input bit gap);
        for (int k = 0; k < len; k++)
        begin
            @(negedge i_core_clk);
            o_rx_valid = 1'b1;
            o_rx_sof   = (k == 0);
            o_rx_eof   = (k == len - 1);
            o_rx_data  = frame[k];
            if (gap && k < len - 1)
            begin
                @(negedge i_core_clk);
                o_rx_valid = 1'b0;
                o_rx_sof   = 1'b0;
                o_rx_data  = ~o_rx_data; // released data keeps moving
            end
        end
        @(negedge i_core_clk);
        o_rx_valid = 1'b0;
        o_rx_sof   = 1'b0;
        o_rx_eof   = 1'b0;
        o_rx_data  = ~o_rx_data;
    endtask
endmodule

/* File: verification/testbench.sv */
// register and wake pattern tests for the wake pattern matcher
`timescale 1ns/1ns
`include "wpm_consts.svh"

module testbench;
    logic        i_core_clk  = 1'b0;
    logic        i_resetn    = 1'b0;
    logic [7:0]  i_reg_addr  = 8'h00;
    logic        i_reg_wr    = 1'b0;
    logic        i_reg_rd    = 1'b0;
    logic [1:0]  i_reg_be    = 2'h3;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [1:0]  en          = 2'h0;
    logic [15:0] o_reg_rdata;
    logic        rx_valid;
    logic        rx_sof;
    logic        rx_eof;
    logic [7:0]  rx_data;
    logic        o_slot1_wake;
    logic        o_slot2_wake;
    int          fails       = 0;
    int          compares    = 0;
    logic [63:0] m;
    logic [31:0] e;
    logic [7:0]  a;
    logic [7:0]  b;

    // 125 MHz core clock
    always #4 i_core_clk = ~i_core_clk;

    wpm_frame_source u_src (.i_core_clk(i_core_clk), .o_rx_valid(rx_valid), .o_rx_sof(rx_sof),
                            .o_rx_eof(rx_eof), .o_rx_data(rx_data));

    wpm_wake_match u_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_be(i_reg_be), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_slot1_detect_enable(en[0]), .i_slot2_detect_enable(en[1]),
        .i_rx_valid(rx_valid), .i_rx_sof(rx_sof), .i_rx_eof(rx_eof), .i_rx_data(rx_data),
        .o_slot1_wake(o_slot1_wake), .o_slot2_wake(o_slot2_wake));

    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic [1:0] be);
        @(negedge i_core_clk);
        i_reg_addr  = ad;
        i_reg_wdata = d;
        i_reg_be    = be;
        i_reg_wr    = 1'b1;
        @(negedge i_core_clk);
        i_reg_wr    = 1'b0;
    endtask

    // one-cycle read strobe, data valid one cycle later
    task automatic rd(input logic [7:0] ad, input logic [15:0] x);
        @(negedge i_core_clk);
        i_reg_addr = ad;
        i_reg_rd   = 1'b1;
        @(negedge i_core_clk);
        i_reg_rd   = 1'b0;
        check(o_reg_rdata, x);
    endtask

    // write, then read the same register on the very next edge
    task automatic wr_rd(input logic [7:0] ad, input logic [15:0] d, input logic [1:0] be, input logic [15:0] x);
        @(negedge i_core_clk);
        i_reg_addr  = ad;
        i_reg_wdata = d;
        i_reg_be    = be;
        i_reg_wr    = 1'b1;
        @(negedge i_core_clk);
        i_reg_wr    = 1'b0;
        i_reg_rd    = 1'b1;
        @(negedge i_core_clk);
        i_reg_rd    = 1'b0;
        check(o_reg_rdata, x);
    endtask

    // send a frame, expect the wake pulse pattern then silence
    task automatic frame_check(input int len, input bit gap, input logic [1:0] x);
        u_src.send(len, gap);
        check({14'h0000, o_slot2_wake, o_slot1_wake}, {14'h0000, x});
        @(negedge i_core_clk);
        check({14'h0000, o_slot2_wake, o_slot1_wake}, 16'h0000);
    endtask

    // reference masked crc, complemented
    function automatic logic [31:0] mcrc(input logic [63:0] mk, input int n);
        logic [31:0] c;
        c = `WPM_CRC_INIT;
        for (int k = 0; k < n && k < 64; k++)
        begin
            if (mk[k])
            begin
                c = c ^ {24'h000000, u_src.frame[k]};
                for (int j = 0; j < 8; j++)
                    c = c[0] ? ((c >> 1) ^ `WPM_CRC_POLY) : (c >> 1);
            end
        end
        return ~c;
    endfunction

    // verdict and end of run
    task automatic wrap_up;
        $display("counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        fails++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        for (int k = 0; k < 80; k++)
            u_src.frame[k] = 8'(k * 37 + 5);
        repeat (8) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_resetn = 1'b1;
        check({14'h0000, o_slot2_wake, o_slot1_wake}, 16'h0000);
        check(o_reg_rdata, `WPM_RST_RDATA);
        for (int r = 0; r < 12; r++)
        begin
            a = (r < 6) ? 8'(8'h40 + 2 * r) : 8'(8'h50 + 2 * (r - 6));
            rd(a, 16'h0000);
            wr_rd(a, {a, ~a}, 2'h3, {a, ~a});
        end
        wr(`WPM_OFS_S1_CRC_LOW, 16'hFFFF, 2'h1);
        rd(`WPM_OFS_S1_CRC_LOW, 16'h40FF);
        wr(`WPM_RSV_A_FIRST, 16'h1234, 2'h3);
        rd(`WPM_RSV_A_FIRST, 16'h0000);
        wr(`WPM_RSV_B_LAST - 8'h01, 16'h5678, 2'h3);
        rd(`WPM_RSV_B_LAST - 8'h01, 16'h0000);
        wr(`WPM_OFS_S1_CRC_HIGH, 16'hFFFF, 2'h2);
        rd(`WPM_OFS_S1_CRC_HIGH, 16'hFFBD);
        rd(`WPM_OFS_S2_MASK_49_64, 16'h5AA5);
        // reset again in mid-run: registers must fall back to zero
        @(negedge i_core_clk);
        i_resetn = 1'b0;
        @(negedge i_core_clk);
        check(o_reg_rdata, `WPM_RST_RDATA);
        check({14'h0000, o_slot2_wake, o_slot1_wake}, 16'h0000);
        i_resetn = 1'b1;
        rd(`WPM_OFS_S2_MASK_49_64, `WPM_RST_MASK);
        rd(`WPM_OFS_S2_MASK_33_48, `WPM_RST_MASK);
        rd(`WPM_OFS_S1_CRC_HIGH, `WPM_RST_CRC);
        $display("test registers done");
        for (int s = 1; s <= 2; s++)
        begin
            a = (s == 1) ? `WPM_OFS_S1_CRC_LOW : `WPM_OFS_S2_CRC_LOW;
            m = 64'h8000_0001_0001_8001;
            e = mcrc(m, 70);
            for (int q = 0; q < 4; q++)
                wr(8'(a + 4 + 2 * q), m[16 * q +: 16], 2'h3);
            wr(a, e[15:0], 2'h3);
            wr(8'(a + 2), e[31:16], 2'h3);
            en = 2'(s);
            frame_check(70, 1'b0, 2'(s));
            u_src.frame[64] = ~u_src.frame[64];
            u_src.frame[1] = ~u_src.frame[1];
            frame_check(70, 1'b1, 2'(s));
            b = u_src.frame[63];
            u_src.frame[63] = ~b;
            frame_check(70, 1'b0, 2'h0);
            u_src.frame[63] = b;
            en = 2'h0;
            frame_check(70, 1'b0, 2'h0);
            $display("test slot %0d done", s);
        end
        wrap_up();
    end
endmodule
